// ==== rtl/rcs_pkg.sv ====
// Package for the reset cause and start-up sequencer.
// Assumes a single 250 MHz clock and an Avalon-MM register slave.
package rcs_pkg;
    // ********************************
    // Register map (word index, byte address = 4 * index)
    // ********************************
    localparam logic [3:0] REG_CAUSE_IDX = 4'h0;
    localparam logic [3:0] REG_BROWNOUT_CONTROL_IDX = 4'h1;
    localparam logic [3:0] REG_STATUS_IDX = 4'h2;
    localparam logic [3:0] REG_CFG_IDX = 4'h3;
    localparam logic [3:0] REG_SEQ_IDX = 4'h4;

    // ********************************
    // Field positions
    // ********************************
    localparam int BIT_BOR = 0;
    localparam int BIT_POR = 1;
    localparam int BIT_RI = 2;
    localparam int BIT_PIN = 3;
    localparam int BIT_WDT = 4;
    localparam int BIT_UNF = 6;
    localparam int BIT_OVF = 7;
    localparam int BIT_PD_N = 3;
    localparam int BIT_TO_N = 4;
    localparam int BIT_BROWNOUT_CONTROL_SBOREN = 7;
    localparam int BIT_BROWNOUT_CONTROL_FS = 6;
    localparam int BIT_BROWNOUT_CONTROL_RDY = 0;
    localparam int BIT_CFG_POWERUP_DELAY_ENABLE = 0;
    localparam int BIT_CFG_STACK_FAULT_RESET_ENABLE = 1;
    localparam int BIT_CFG_PINEN = 2;
    localparam int BIT_CFG_OSTREQ = 3;

    // ********************************
    // Reset values and masks
    // ********************************
    localparam logic [7:0] CAUSE_WMASK = 8'hDF;
    localparam logic [7:0] CAUSE_POR_VAL = 8'h1C;
    localparam logic [7:0] BROWNOUT_CONTROL_WMASK = 8'hC0;
    localparam logic [7:0] BROWNOUT_CONTROL_RST = 8'h80;
    localparam logic [7:0] CFG_RST = 8'h07;
    localparam logic [1:0] STATUS_POR = 2'h3;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PC_IRQ_VEC = 16'h0004;
    localparam logic [15:0] PC_STEP = 16'h0001;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_MHZ = 250;
    localparam int PIN_RELEASE_CYC = 10;
    localparam int POWERUP_DELAY_TIMER_US = 64;
    localparam int POWERUP_DELAY_TIMER_CYC = POWERUP_DELAY_TIMER_US * CLK_MHZ;
    localparam int OST_CYC = 1024;

    // ********************************
    // Types
    // ********************************
    typedef enum logic [1:0] {
        RCS_HOLD = 2'h0,
        RCS_WAIT = 2'h1,
        RCS_DELAY = 2'h3,
        RCS_RUN = 2'h2
    } rcs_state_t;

    typedef struct packed {
        logic por;
        logic bor;
        logic low_power_brownout;
        logic wdt;
        logic pin;
        logic rst_instr;
        logic stk_ovf;
        logic stk_unf;
        logic wake_wdt;
        logic wake_irq;
        logic asleep;
    } rcs_event_t;

    typedef struct packed {
        logic load;
        logic [15:0] value;
        logic push;
    } rcs_pc_t;
endpackage

// ==== rtl/rcs_timer.sv ====
// One-shot start-up timer.
// Assumes start is a single-cycle pulse on ref_clk.
`timescale 1ns/1ps
module rcs_timer #(
    parameter int COUNT = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic enable,
    // Status
    output logic done
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT);
    logic [W-1:0] cnt_r;
    logic run_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else if (start) begin
            cnt_r <= '0;
            run_r <= enable;
        end else if (run_r) begin
            cnt_r <= cnt_r + W'(1);
            if (cnt_r == LAST - W'(1)) begin
                run_r <= 1'b0;
            end
        end
    end

    assign done = !run_r && !start;
endmodule

// ==== rtl/rcs_top.sv ====
// Reset cause recording and start-up sequencing.
// Assumes event inputs are single-cycle pulses on ref_clk; pin is async.
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module rcs_top #(
    parameter int POWERUP_DELAY_TIMER_COUNT = rcs_pkg::POWERUP_DELAY_TIMER_CYC,
    parameter int OST_COUNT = rcs_pkg::OST_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Reset and wake events
    input wire rcs_pkg::rcs_event_t events,
    input wire logic [15:0] cur_pc,
    input wire logic global_interrupt_enable,
    input wire logic external_reset_pin_n,
    input wire logic brownout_ready,
    // Core control
    output logic core_run,
    output logic core_reset,
    output rcs_pkg::rcs_pc_t pc_ctl
);
    // ********************************
    // Pin synchroniser
    // ********************************
    logic pin_s1_r;
    logic pin_s2_r;
    logic pin_prev_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= 1'b0;
            pin_s2_r <= 1'b0;
            pin_prev_r <= 1'b0;
        end else begin
            pin_s1_r <= external_reset_pin_n;
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    // ********************************
    // Registers
    // ********************************
    logic [7:0] cause_r;
    logic [7:0] brownout_control_r;
    logic [1:0] status_r;
    logic [7:0] cfg_r;
    logic powerup_delay_enable;
    logic stack_fault_reset_enable;
    logic pin_en;
    logic ost_req;
    logic pin_held;
    logic pin_rise;

    assign powerup_delay_enable = cfg_r[rcs_pkg::BIT_CFG_POWERUP_DELAY_ENABLE];
    assign stack_fault_reset_enable = cfg_r[rcs_pkg::BIT_CFG_STACK_FAULT_RESET_ENABLE];
    assign pin_en = cfg_r[rcs_pkg::BIT_CFG_PINEN];
    assign ost_req = cfg_r[rcs_pkg::BIT_CFG_OSTREQ];
    assign pin_held = pin_en && !pin_s2_r;
    assign pin_rise = pin_en && pin_s2_r && !pin_prev_r;

    // ********************************
    // Event decode
    // ********************************
    logic bor_any;
    logic pwr_evt;
    logic stk_rst;
    logic pin_rst;
    logic any_rst;
    logic wake;

    assign bor_any = events.bor || events.low_power_brownout;
    assign pwr_evt = events.por || bor_any;
    assign stk_rst = stack_fault_reset_enable && (events.stk_ovf || events.stk_unf);
    assign pin_rst = pin_en && !pin_s2_r && pin_prev_r;
    assign any_rst = pwr_evt || events.wdt || pin_rst || events.rst_instr || stk_rst;
    assign wake = events.wake_wdt || events.wake_irq;

    // ********************************
    // Bus slave
    // ********************************
    logic wr_hit;
    logic wr_cause;
    logic wr_brownout_control;
    logic wr_cfg;
    logic ack_r;

    assign wr_hit = avs_write && avs_byteenable[0] && !avs_waitrequest;
    assign wr_cause = wr_hit && avs_address == rcs_pkg::REG_CAUSE_IDX;
    assign wr_brownout_control = wr_hit && avs_address == rcs_pkg::REG_BROWNOUT_CONTROL_IDX;
    assign wr_cfg = wr_hit && avs_address == rcs_pkg::REG_CFG_IDX;
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read || avs_write) && !ack_r;
        end
    end

    // ********************************
    // Reset cause flags
    // ********************************
    logic [7:0] cause_nxt;

    always_comb begin
        cause_nxt = cause_r;
        if (wr_cause) begin
            cause_nxt = avs_writedata[7:0] & rcs_pkg::CAUSE_WMASK;
        end
        // Hardware below overrides the write
        if (events.stk_ovf) begin
            cause_nxt[rcs_pkg::BIT_OVF] = 1'b1;
        end
        if (events.stk_unf) begin
            cause_nxt[rcs_pkg::BIT_UNF] = 1'b1;
        end
        if (events.wdt) begin
            cause_nxt[rcs_pkg::BIT_WDT] = 1'b0;
        end
        if (pin_rst) begin
            cause_nxt[rcs_pkg::BIT_PIN] = 1'b0;
        end
        if (events.rst_instr) begin
            cause_nxt[rcs_pkg::BIT_RI] = 1'b0;
        end
        if (bor_any) begin
            cause_nxt[rcs_pkg::BIT_OVF] = 1'b0;
            cause_nxt[rcs_pkg::BIT_UNF] = 1'b0;
            cause_nxt[rcs_pkg::BIT_WDT] = 1'b1;
            cause_nxt[rcs_pkg::BIT_PIN] = 1'b1;
            cause_nxt[rcs_pkg::BIT_RI] = 1'b1;
            cause_nxt[rcs_pkg::BIT_BOR] = 1'b0;
        end
        if (events.por) begin
            cause_nxt = rcs_pkg::CAUSE_POR_VAL;
            cause_nxt[rcs_pkg::BIT_BOR] = !bor_any ? cause_r[rcs_pkg::BIT_BOR] : 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cause_r <= rcs_pkg::CAUSE_POR_VAL;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // ********************************
    // Timeout and power-down flags
    // ********************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            status_r <= rcs_pkg::STATUS_POR;
        end else if (pwr_evt) begin
            status_r <= rcs_pkg::STATUS_POR;
        end else if (events.wake_wdt) begin
            status_r <= 2'h0;
        end else if (events.wdt) begin
            status_r[1] <= 1'b0;
        end else if ((pin_rst && events.asleep) || events.wake_irq) begin
            status_r <= 2'h2;
        end
    end

    // ********************************
    // Brown-out control and configuration
    // ********************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            brownout_control_r <= rcs_pkg::BROWNOUT_CONTROL_RST;
        end else if (pwr_evt) begin
            brownout_control_r <= rcs_pkg::BROWNOUT_CONTROL_RST;
        end else if (wr_brownout_control) begin
            brownout_control_r <= avs_writedata[7:0] & rcs_pkg::BROWNOUT_CONTROL_WMASK;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= rcs_pkg::CFG_RST;
        end else if (wr_cfg) begin
            cfg_r <= avs_writedata[7:0];
        end
    end

    // ********************************
    // Start-up timers
    // ********************************
    logic powerup_delay_timer_done;
    logic ost_done;
    logic seq_start;
    logic timers_done;

    assign seq_start = pwr_evt;

    rcs_timer #(
        .COUNT(POWERUP_DELAY_TIMER_COUNT)
    ) u_powerup_delay_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(seq_start),
        .enable(powerup_delay_enable),
        .done(powerup_delay_timer_done)
    );

    rcs_timer #(
        .COUNT(OST_COUNT)
    ) u_ost (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(seq_start),
        .enable(ost_req),
        .done(ost_done)
    );

    assign timers_done = powerup_delay_timer_done && ost_done;

    // ********************************
    // Sequencer
    // ********************************
    localparam int DW = $clog2(rcs_pkg::PIN_RELEASE_CYC + 1);
    localparam logic [DW-1:0] DLY_LAST = DW'(rcs_pkg::PIN_RELEASE_CYC - 1);
    rcs_pkg::rcs_state_t state_r;
    logic [DW-1:0] dly_r;
    logic irq_pend_r;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= rcs_pkg::RCS_HOLD;
            dly_r <= '0;
        end else if (any_rst || pin_held) begin
            state_r <= rcs_pkg::RCS_HOLD;
            dly_r <= '0;
        end else begin
            case (state_r)
                rcs_pkg::RCS_HOLD: begin
                    // Rise after a held pin lands here
                    if (timers_done && pin_rise) begin
                        state_r <= rcs_pkg::RCS_DELAY;
                    end else begin
                        state_r <= rcs_pkg::RCS_WAIT;
                    end
                end
                rcs_pkg::RCS_WAIT: begin
                    if (timers_done && pin_rise) begin
                        state_r <= rcs_pkg::RCS_DELAY;
                    end else if (timers_done) begin
                        state_r <= rcs_pkg::RCS_RUN;
                    end
                end
                rcs_pkg::RCS_DELAY: begin
                    dly_r <= dly_r + DW'(1);
                    if (dly_r == DLY_LAST - DW'(1)) begin
                        state_r <= rcs_pkg::RCS_RUN;
                    end
                end
                rcs_pkg::RCS_RUN: begin
                    state_r <= rcs_pkg::RCS_RUN;
                end
                default: begin
                    state_r <= rcs_pkg::RCS_HOLD;
                end
            endcase
        end
    end

    assign core_run = state_r == rcs_pkg::RCS_RUN;
    assign core_reset = state_r == rcs_pkg::RCS_HOLD;

    // ********************************
    // Program counter control
    // ********************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pc_ctl <= '{load: 1'b1, value: rcs_pkg::PC_RESET, push: 1'b0};
            irq_pend_r <= 1'b0;
        end else if (any_rst) begin
            pc_ctl <= '{load: 1'b1, value: rcs_pkg::PC_RESET, push: 1'b0};
            irq_pend_r <= 1'b0;
        end else if (wake) begin
            pc_ctl <= '{load: 1'b1, value: cur_pc + rcs_pkg::PC_STEP, push: 1'b0};
            irq_pend_r <= events.wake_irq && global_interrupt_enable;
        end else if (irq_pend_r) begin
            pc_ctl <= '{load: 1'b1, value: rcs_pkg::PC_IRQ_VEC, push: 1'b1};
            irq_pend_r <= 1'b0;
        end else begin
            pc_ctl <= '{load: 1'b0, value: pc_ctl.value, push: 1'b0};
        end
    end

    // ********************************
    // Read mux
    // ********************************
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            avs_readdata <= '0;
        end else if (avs_read && !ack_r) begin
            case (avs_address)
                rcs_pkg::REG_CAUSE_IDX: avs_readdata <= {24'h000000, cause_r};
                rcs_pkg::REG_BROWNOUT_CONTROL_IDX: begin
                    avs_readdata <= {24'h000000, brownout_control_r[7:1], brownout_ready};
                end
                rcs_pkg::REG_STATUS_IDX: avs_readdata <= {27'h0000000, status_r, 3'h0};
                rcs_pkg::REG_CFG_IDX: avs_readdata <= {24'h000000, cfg_r};
                rcs_pkg::REG_SEQ_IDX: avs_readdata <= {28'h0000000, powerup_delay_timer_done, ost_done, state_r};
                default: avs_readdata <= '0;
            endcase
        end
    end
endmodule

// ==== verif/rcs_top_properties.sv ====
// Concurrent checks on the reset cause and start-up sequencer ports.
// Assumes it is bound onto rcs_top, single clock domain.
`timescale 1ns/1ps
module rcs_top_properties #(
    parameter int POWERUP_DELAY_TIMER_COUNT = rcs_pkg::POWERUP_DELAY_TIMER_CYC,
    parameter int OST_COUNT = rcs_pkg::OST_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Bus
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Events
    input wire rcs_pkg::rcs_event_t events,
    input wire logic [15:0] cur_pc,
    input wire logic global_interrupt_enable,
    input wire logic external_reset_pin_n,
    // Core
    input wire logic core_run,
    input wire logic core_reset,
    input wire rcs_pkg::rcs_pc_t pc_ctl
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // ****************************
    // Sequences and properties
    // ****************************
    sequence s_step;
        pc_ctl.load && pc_ctl.value == $past(cur_pc) + 16'h0001;
    endsequence
    sequence s_vec;
        pc_ctl.push && pc_ctl.value == 16'h0004;
    endsequence
    property p_boot_hold;
        $rose(nrst) |-> !core_run [*8];
    endproperty
    property p_pin_delay;
        $rose(external_reset_pin_n) && !core_run |-> !core_run [*8];
    endproperty
    property p_hold_idle;
        core_reset |-> !core_run;
    endproperty
    property p_reset_pc;
        events.por || events.bor || events.low_power_brownout || events.rst_instr
            || (events.wdt && !events.asleep) |=> pc_ctl.load && pc_ctl.value == 16'h0000;
    endproperty
    property p_wake_pc;
        events.wake_wdt |=> s_step;
    endproperty
    property p_irq_vec;
        events.wake_irq && global_interrupt_enable |=> s_step ##1 s_vec;
    endproperty
    property p_irq_plain;
        events.wake_irq && !global_interrupt_enable |=> ##1 !pc_ctl.push;
    endproperty
    property p_gap_bit;
        avs_read && !avs_waitrequest && avs_address == rcs_pkg::REG_CAUSE_IDX
            |-> avs_readdata[5] == 1'b0;
    endproperty

    // ****************************
    // Assertions
    // ****************************
    a_boot_hold: assert property (p_boot_hold) else $error("core ran in start-up hold");
    a_pin_delay: assert property (p_pin_delay) else $error("core ran too soon");
    a_hold_idle: assert property (p_hold_idle) else $error("core ran in hold");
    a_reset_pc: assert property (p_reset_pc) else $error("reset pc not zero");
    a_wake_pc: assert property (p_wake_pc) else $error("wake pc not next");
    a_irq_vec: assert property (p_irq_vec) else $error("irq vector missing");
    a_irq_plain: assert property (p_irq_plain) else $error("push without enable");
    a_gap_bit: assert property (p_gap_bit) else $error("bit five not zero");
endmodule

bind rcs_top rcs_top_properties #(.POWERUP_DELAY_TIMER_COUNT(POWERUP_DELAY_TIMER_COUNT), .OST_COUNT(OST_COUNT))
    rcs_top_properties_inst (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .events(events), .cur_pc(cur_pc), .global_interrupt_enable(global_interrupt_enable),
    .external_reset_pin_n(external_reset_pin_n), .core_run(core_run),
    .core_reset(core_reset), .pc_ctl(pc_ctl));

// ==== verif/tb_rcs_top.sv ====
// Bench for the reset cause and start-up sequencer.
// Assumes rcs_pkg and rcs_top compiled first.
`timescale 1ns/1ps
module tb_rcs_top;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [10:0] events = 11'h000;
    logic [15:0] cur_pc = 16'h1234;
    logic global_interrupt_enable = 1'b1;
    logic pin_n = 1'b0;
    logic core_run;
    logic core_reset;
    rcs_pkg::rcs_pc_t pc_ctl;
    logic [31:0] rd;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;

    rcs_top #(.POWERUP_DELAY_TIMER_COUNT(20), .OST_COUNT(8)) rcs_top_inst (
        .ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .events(events),
        .cur_pc(cur_pc), .global_interrupt_enable(global_interrupt_enable),
        .external_reset_pin_n(pin_n), .brownout_ready(1'b1), .core_run(core_run),
        .core_reset(core_reset), .pc_ctl(pc_ctl));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // ****************************
    // Tasks
    // ****************************
    task automatic close_out();
        if (error_cnt == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rd, {24'h0, e});
    endtask

    // Event order: por bor low_power_brownout wdt pin rst ovf unf wwake iwake asleep
    task automatic pulse(input logic [10:0] e);
        @(posedge ref_clk);
        events <= e;
        @(posedge ref_clk);
        events <= e & 11'h001;
        #1;
    endtask

    task automatic pcchk(input logic l, input logic [15:0] v);
        chk({15'h0, pc_ctl.load, pc_ctl.value}, {15'h0, l, v});
    endtask

    task automatic release_pin(input int lim);
        int n;
        n = 0;
        @(posedge ref_clk);
        pin_n <= 1'b1;
        repeat (11) @(posedge ref_clk);
        #1 chk({31'h0, core_run}, 32'h0);
        while (core_run !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            #1 n++;
        end
        chk({31'h0, n < lim}, 32'h1);
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    // ****************************
    // Main sequence
    // ****************************
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        rchk(rcs_pkg::REG_CAUSE_IDX, 8'h1C);
        rchk(rcs_pkg::REG_STATUS_IDX, 8'h18);
        rchk(rcs_pkg::REG_BROWNOUT_CONTROL_IDX, 8'h81);
        rchk(rcs_pkg::REG_CFG_IDX, 8'h07);
        pulse(11'h400);
        bus(1'b0, rcs_pkg::REG_SEQ_IDX, 8'h00);
        chk(rd & 32'h8, 32'h0);
        repeat (30) @(posedge ref_clk);
        #1 chk({31'h0, core_run}, 32'h0);
        bus(1'b0, rcs_pkg::REG_SEQ_IDX, 8'h00);
        chk(rd & 32'h8, 32'h8);
        release_pin(2);
        bus(1'b1, 4'h0, 8'hFF);
        rchk(4'h0, 8'hDF);
        fork
            bus(1'b1, 4'h0, 8'hFF);
            begin
                @(posedge ref_clk);
                pulse(11'h200);
            end
        join
        rchk(4'h0, 8'h1E);
        bus(1'b1, 4'h0, 8'hFF);
        pulse(11'h080);
        pcchk(1'b1, 16'h0000);
        rchk(4'h0, 8'hCF);
        rchk(4'h2, 8'h08);
        pulse(11'h020);
        rchk(4'h0, 8'hCB);
        pulse(11'h001);
        @(posedge ref_clk);
        pin_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rchk(4'h0, 8'hC3);
        rchk(4'h2, 8'h10);
        release_pin(2);
        pulse(11'h005);
        pcchk(1'b1, 16'h1235);
        rchk(4'h2, 8'h00);
        pulse(11'h003);
        pcchk(1'b1, 16'h1235);
        @(posedge ref_clk);
        #1 chk({15'h0, pc_ctl.push, pc_ctl.value}, 32'h10004);
        rchk(4'h2, 8'h10);
        global_interrupt_enable <= 1'b0;
        pulse(11'h003);
        @(posedge ref_clk);
        #1 chk({31'h0, pc_ctl.push}, 32'h0);
        pulse(11'h000);
        bus(1'b1, 4'h0, 8'h1F);
        pulse(11'h010);
        pcchk(1'b1, 16'h0000);
        rchk(4'h0, 8'h9F);
        bus(1'b1, 4'h3, 8'h05);
        pulse(11'h008);
        chk({31'h0, pc_ctl.load}, 32'h0);
        rchk(4'h0, 8'hDF);
        bus(1'b1, 4'h0, 8'h1F);
        pulse(11'h100);
        rchk(4'h0, 8'h1E);
        bus(1'b1, 4'h0, 8'h1F);
        pulse(11'h200);
        rchk(4'h0, 8'h1E);
        pulse(11'h400);
        pcchk(1'b1, 16'h0000);
        bus(1'b0, 4'h0, 8'h00);
        chk(rd & 32'hFE, 32'h1C);
        rchk(4'h2, 8'h18);
        rchk(4'hF, 8'h00);
        close_out();
    end
endmodule
